//--- logic/irq_source_map.sv
`timescale 1ns/100ps
`default_nettype none
module irq_source_map
  import irq_map_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  // core-internal sources, held levels until acknowledged
  input  wire logic                 cpu_internal_timer_in,
  input  wire logic                 watchdog_trigger_in,
  // dma sources, held levels from the dma engine
  input  wire logic [DMA_CH_N-1:0]  dma_complete_in,
  input  wire logic [DMA_CH_N-1:0]  dma_fault_in,
  // host interface side
  input  wire logic                 host_mode_spi_in,
  input  wire logic                 host_i2c_stop_in,
  input  wire logic                 host_chip_select_n_in,
  input  wire logic                 host_evt_wr_in,
  input  wire logic [7:0]           host_evt_data_in,
  // firmware clears for the host sources
  input  wire logic                 host_comm_clr_in,
  input  wire logic                 host_sw_event_clr_in,
  // processor interrupt vector and event marker
  output logic [IRQ_VEC_W-1:0]      irq_out,
  output logic                      host_sw_event_line_out
);
  // pin synchroniser for the host chip select, idle high
  logic [2:0] csn_sync_q;
  // filtered chip select level, taken from stage three once stages two and three agree
  logic       csn_stable_q;
  logic       comm_evt;
  logic       hevt_evt;
  logic [IRQ_VEC_W-1:0] irq_d;

  irq_src_if comm_if ();
  irq_src_if hevt_if ();

  // three flops; a change is believed once stages two and three agree
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      csn_sync_q <= 3'h7;
    end
    else
    begin
      csn_sync_q <= {csn_sync_q[1:0], host_chip_select_n_in};
    end
  end

  // filtered chip select level, reset deasserted
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      csn_stable_q <= 1'b1;
    end
    else if (csn_sync_q[1] == csn_sync_q[2])
    begin
      csn_stable_q <= csn_sync_q[2];
    end
  end

  // transaction end detection
  // spi: filtered rising edge of chip select; i2c: stop strobe
  always_comb
  begin
    if (host_mode_spi_in == HOST_MODE_SPI)
    begin
      comm_evt = !csn_stable_q && (csn_sync_q[1] == csn_sync_q[2]) && csn_sync_q[2];
    end
    else
    begin
      comm_evt = host_i2c_stop_in;
    end
  end

  // host write of one to bit 0
  assign hevt_evt = host_evt_wr_in && host_evt_data_in[HEVT_REQ_BIT];

  assign comm_if.set_evt = comm_evt;
  assign comm_if.clr_evt = host_comm_clr_in;
  assign hevt_if.set_evt = hevt_evt;
  assign hevt_if.clr_evt = host_sw_event_clr_in;

  irq_sticky comm_latch
  (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .src        (comm_if.latch)
  );

  irq_sticky hevt_latch
  (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .src        (hevt_if.latch)
  );

  // line map; unmapped lines stay low
  always_comb
  begin
    irq_d = '0;
    irq_d[IRQ_TIMER_LINE] = cpu_internal_timer_in;
    irq_d[IRQ_WDOG_LINE]  = watchdog_trigger_in;
    irq_d[IRQ_DMA0_LINE]  = dma_complete_in[0];
    irq_d[IRQ_DMA1_LINE]  = dma_complete_in[1];
    irq_d[IRQ_DMA2_LINE]  = dma_complete_in[2];
    irq_d[IRQ_DMA3_LINE]  = dma_complete_in[3];
    irq_d[IRQ_DMAERR_LINE] = |dma_fault_in;
    irq_d[IRQ_HCOMM_LINE] = comm_if.pending;
    irq_d[IRQ_HEVT_LINE]  = hevt_if.pending;
  end

  // dma levels go straight to the core, only a register stage
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_out <= '0;
    end
    else
    begin
      irq_out <= irq_d;
    end
  end

  // event-capable marker, one cycle on each request
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      host_sw_event_line_out <= 1'b0;
    end
    else
    begin
      host_sw_event_line_out <= hevt_evt;
    end
  end

  // timer and watchdog follow their source one cycle later
  timer_map_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |->
    irq_out[IRQ_TIMER_LINE] == $past(cpu_internal_timer_in)
    && irq_out[IRQ_WDOG_LINE] == $past(watchdog_trigger_in))
    else $error("timer or watchdog line mismatch");

  // channel done lines, each one cycle behind its own channel
  dma_done_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |->
    {irq_out[IRQ_DMA3_LINE], irq_out[IRQ_DMA2_LINE], irq_out[IRQ_DMA1_LINE],
     irq_out[IRQ_DMA0_LINE]} == $past(dma_complete_in))
    else $error("dma done line mismatch");

  // merged fault line
  dma_fault_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (|dma_fault_in) |=> irq_out[IRQ_DMAERR_LINE])
    else $error("dma fault line not raised");

  // direct path: fault drop clears line next cycle
  dma_direct_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (dma_fault_in == '0) |=> !irq_out[IRQ_DMAERR_LINE])
    else $error("dma fault line stuck");

  sequence i2c_stop_s;
    !host_mode_spi_in && host_i2c_stop_in;
  endsequence

  // stop raises host comm line two cycles later
  host_comm_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    i2c_stop_s |=> ##1 irq_out[IRQ_HCOMM_LINE])
    else $error("host comm line missing");

  sequence hevt_req_s;
    host_evt_wr_in && host_evt_data_in[HEVT_REQ_BIT];
  endsequence

  // host event raises marker then level
  host_event_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    hevt_req_s |=> host_sw_event_line_out ##1 irq_out[IRQ_HEVT_LINE])
    else $error("host event not raised");

  // line held until firmware clear
  line_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    irq_out[IRQ_HEVT_LINE] && !$past(host_sw_event_clr_in) |=> irq_out[IRQ_HEVT_LINE])
    else $error("host event line dropped early");

  // host comm held without clear
  comm_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $past(comm_if.pending) && !$past(host_comm_clr_in) |-> comm_if.pending)
    else $error("host comm latch dropped");

  // marker stands only in a cycle that follows a request, low after any cycle without one
  event_pulse_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !(host_evt_wr_in && host_evt_data_in[HEVT_REQ_BIT]) |=> !host_sw_event_line_out)
    else $error("host event marker without request");

  sequence hevt_clear_s;
    host_sw_event_clr_in && !hevt_evt;
  endsequence

  // clear with no new request drops the event line two cycles later
  hevt_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    hevt_clear_s |=> ##1 !irq_out[IRQ_HEVT_LINE])
    else $error("host event line not cleared");

  sequence comm_clear_s;
    host_comm_clr_in && !comm_evt;
  endsequence

  // clear with no new transaction end drops the comm line two cycles later
  comm_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    comm_clear_s |=> ##1 !irq_out[IRQ_HCOMM_LINE])
    else $error("host comm line not cleared");
endmodule
`default_nettype wire

//--- logic/irq_map_pkg.sv
package irq_map_pkg;
  // processor interrupt line numbers
  localparam int unsigned IRQ_TIMER_LINE = 16;
  localparam int unsigned IRQ_DMA0_LINE  = 17;
  localparam int unsigned IRQ_WDOG_LINE  = 18;
  localparam int unsigned IRQ_DMA1_LINE  = 19;
  localparam int unsigned IRQ_DMA2_LINE  = 20;
  localparam int unsigned IRQ_DMA3_LINE  = 21;
  localparam int unsigned IRQ_HCOMM_LINE = 22;
  localparam int unsigned IRQ_HEVT_LINE  = 30;
  localparam int unsigned IRQ_DMAERR_LINE = 34;
  // width of the processor interrupt vector (lines 0..40)
  localparam int unsigned IRQ_VEC_W = 41;
  // dma channel count
  localparam int unsigned DMA_CH_N = 4;
  // bit of the timestamp event request write that raises the host event
  localparam int unsigned HEVT_REQ_BIT = 0;
  // host link modes
  typedef enum logic [0:0] {
    HOST_MODE_I2C = 1'b0,
    HOST_MODE_SPI = 1'b1
  } host_mode_t;
endpackage

//--- logic/irq_src_if.sv
`timescale 1ns/100ps
`default_nettype none
// sticky source latch: set by an event, cleared by firmware
interface irq_src_if;
  logic set_evt;   // one-cycle event
  logic clr_evt;   // one-cycle firmware clear
  logic pending;   // held level
  modport owner (output set_evt, output clr_evt, input pending);
  modport latch (input set_evt, input clr_evt, output pending);
endinterface
`default_nettype wire

//--- logic/irq_sticky.sv
`timescale 1ns/100ps
`default_nettype none
module irq_sticky
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // source handshake
  irq_src_if.latch  src
);
  // pending level, set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src.pending <= 1'b0;
    end
    else if (src.set_evt)
    begin
      src.pending <= 1'b1;
    end
    else if (src.clr_evt)
    begin
      src.pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/core_irq_sink.sv
`timescale 1ns/100ps
`default_nettype none
// core side model: firmware acks latched host lines when allowed
module core_irq_sink
  import irq_map_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // interrupt vector and ack permission
  input  wire logic [IRQ_VEC_W-1:0] irq_in,
  input  wire logic                 ack_en_in,
  // firmware clears toward the sources
  output logic                      comm_clr_out,
  output logic                      evt_clr_out
);
  // clear at source
  // one pulse per pass, gap avoids a stuck clear
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      comm_clr_out <= 1'b0;
      evt_clr_out  <= 1'b0;
    end
    else
    begin
      comm_clr_out <= ack_en_in & irq_in[IRQ_HCOMM_LINE] & ~comm_clr_out;
      evt_clr_out  <= ack_en_in & irq_in[IRQ_HEVT_LINE] & ~evt_clr_out;
    end
endmodule
`default_nettype wire

//--- tb/mcu_interrupt_source_mapping_test.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_interrupt_source_mapping_test;
  import irq_map_pkg::*;
  logic                 clk, rst, tmr, wdg, spi, stp, csn, ewr, ack, cclr, eclr, evl;
  logic [3:0]           dmc, dmf;     // dma done and fault levels
  logic [7:0]           edat;         // host event write data
  logic [IRQ_VEC_W-1:0] irq;          // processor vector
  int                   mismatches, compares, cyc;
  logic [31:0]          seed = 32'hd02cc547;

  irq_source_map dut (.ref_clk_in(clk), .rst_in(rst), .cpu_internal_timer_in(tmr),
    .watchdog_trigger_in(wdg), .dma_complete_in(dmc), .dma_fault_in(dmf),
    .host_mode_spi_in(spi), .host_i2c_stop_in(stp), .host_chip_select_n_in(csn),
    .host_evt_wr_in(ewr), .host_evt_data_in(edat), .host_comm_clr_in(cclr),
    .host_sw_event_clr_in(eclr), .irq_out(irq), .host_sw_event_line_out(evl));
  core_irq_sink core (.clk_in(clk), .rst_in(rst), .irq_in(irq), .ack_en_in(ack),
    .comm_clr_out(cclr), .evt_clr_out(eclr));

  // 200 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected vector with host lines idle
  function automatic logic [IRQ_VEC_W-1:0] exp_vec(input logic [9:0] s);
    exp_vec = '0;
    exp_vec[IRQ_TIMER_LINE] = s[9];
    exp_vec[IRQ_WDOG_LINE] = s[8];
    exp_vec[IRQ_DMA0_LINE] = s[4];
    exp_vec[IRQ_DMA1_LINE] = s[5];
    exp_vec[IRQ_DMA2_LINE] = s[6];
    exp_vec[IRQ_DMA3_LINE] = s[7];
    exp_vec[IRQ_DMAERR_LINE] = |s[3:0];
  endfunction

  task automatic check(input string nm, input logic [IRQ_VEC_W-1:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait on one vector bit, then compare
  task automatic wait_bit(input int idx, input logic v, input int lim, input string nm);
    for (int i = 0; i < lim && irq[idx] !== v; i++) tick(1);
    check(nm, irq[idx], v);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, run needs well under this
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    {tmr, wdg, spi, stp, ewr, ack, dmc, dmf, edat} = '0;
    csn = 1'b1;
    rst = 1'b1;
    tick(2);
    check("reset vector", irq, '0);
    rst = 1'b0;
    // corners all-off and all-on, then random levels
    for (int i = 0; i < 200; i++)
    begin
      seed = lfsr(seed);
      {tmr, wdg, dmc, dmf} = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : seed[9:0];
      tick(1);
      check("direct lines", irq, exp_vec({tmr, wdg, dmc, dmf}));
    end
    {tmr, wdg, dmc, dmf} = '0;
    $display("test direct lines ended");
    for (int b = 0; b < 2; b++)
    begin
      ewr = 1'b1;
      edat = {seed[7:1], b[0]};
      tick(1);
      ewr = 1'b0;
      check("event pulse", evl, b[0]);
      tick(1);
      check("event pulse end", evl, 1'b0);
      check("event line", irq[IRQ_HEVT_LINE], b[0]);
    end
    tick(5);
    check("event line held", irq[IRQ_HEVT_LINE], 1'b1);
    ack = 1'b1;
    wait_bit(IRQ_HEVT_LINE, 1'b0, 6, "event cleared");
    ack = 1'b0;
    $display("test host event ended");
    // stop or chip select in each mode
    for (int m = 0; m < 4; m++)
    begin
      spi = m[1];
      tick(2);
      csn = ~m[0];
      stp = ~m[0];
      tick(m[0] ? 3 : 1);
      csn = 1'b1;
      stp = 1'b0;
      // refused case: wait past the filter latency before looking
      if (m[1] != m[0])
        tick(8);
      wait_bit(IRQ_HCOMM_LINE, m[1] == m[0], 8, "transaction end");
      check("no event line", irq[IRQ_HEVT_LINE], 1'b0);
      ack = 1'b1;
      wait_bit(IRQ_HCOMM_LINE, 1'b0, 6, "comm cleared");
      ack = 1'b0;
    end
    $display("test host comm ended");
    end_of_test();
  end
endmodule
`default_nettype wire
